// file: rtl/digit_intensity_map.vh
// Purpose: Register offsets, fields and timing of the intensity block
// Assumes: Register writes arrive as address/data strobes from the bus
// Notes: Offsets are the documented address codes
`ifndef DIGIT_INTENSITY_MAP_VH
`define DIGIT_INTENSITY_MAP_VH
`define ADDR_INTENSITY_01 8'h01
`define ADDR_INTENSITY_23 8'h02
`define ADDR_LAMP_TEST 8'h07
`define LOW_NIB_LSB 0
`define HIGH_NIB_LSB 4
`define TEST_BIT 0
`define RESET_INTENSITY 8'h00
`define RESET_TEST 1'b0
`define SLOT_BITS 4
`define SLOT_LAST 4'hF
`define TEST_DUTY 4'h7
`define MAX_CODE 4'hE
`define DIGIT_PERIOD_CYCLES 100
`endif

// file: rtl/digit_intensity_test_ctrl.v
// Purpose: Per-digit PWM brightness and display-test override
// Assumes: Register write strobe comes from the serial bus slave, same clock
// Notes: Digit period splits into 16 slots; enables are per-digit on-times
//
// Behaviour
// R1: Address 0x07 bit D0 selects normal or display test; D7-D1 ignored.
// R2: Low nibbles of 0x01 and 0x02 set digit 0 and digit 2 codes.
// R3: High nibbles of 0x01 and 0x02 set digit 1 and digit 3 codes.
// R4: Code n gives (n+1)/16 on-time; code 15 same as code 14.
// R5: Master limits bus to 100kbps at low supply after 2.7V power-up.
// R6: Display test lights everything at 7/16, registers left untouched.
// R7: Four independent modulators, 16 steps, at least 1/16 blanking.
// R8: New settings take effect at start of next digit period.
`timescale 1ns/100ps
`include "digit_intensity_map.vh"
module digit_intensity_test_ctrl #(
  parameter DIGITS = 4,
  parameter SLOT_CYCLES = `DIGIT_PERIOD_CYCLES / 16
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_rd_addr_valid,
  output reg [7:0] o_rdata,
  output reg [DIGITS-1:0] o_digit_on,
  output reg o_test_active,
  output reg o_period_start
);

////////////////////////////////////////////////////////////////////////
// Registers written over the bus

reg [7:0] intensity_digits_zero_one_q;
reg [7:0] intensity_digits_zero_one_d;
reg [7:0] intensity_digits_two_three_q;
reg [7:0] intensity_digits_two_three_d;
reg test_q;
reg test_d;
reg [7:0] rdata_d;
reg [7:0] slot_cnt_q;
reg [7:0] slot_cnt_d;
reg [3:0] slot_q;
reg [3:0] slot_d;
reg [15:0] codes_q;
reg test_live_q;
wire slot_end;
wire period_end;

// Write decode; unmapped addresses leave every register alone
always @* begin
  intensity_digits_zero_one_d = intensity_digits_zero_one_q;
  intensity_digits_two_three_d = intensity_digits_two_three_q;
  test_d = test_q;
  if (i_wr) begin
    case (i_addr)
      `ADDR_INTENSITY_01: begin
        intensity_digits_zero_one_d = i_wdata; // [R2] [R3]
      end
      `ADDR_INTENSITY_23: begin
        intensity_digits_two_three_d = i_wdata; // [R2] [R3]
      end
      `ADDR_LAMP_TEST: begin
        test_d = i_wdata[`TEST_BIT]; // [R1]
      end
      default: begin
        test_d = test_q;
      end
    endcase
  end
end

always @(posedge i_clk or negedge i_nrst) begin
  if (!i_nrst) begin
    intensity_digits_zero_one_q <= `RESET_INTENSITY;
    intensity_digits_two_three_q <= `RESET_INTENSITY;
    test_q <= `RESET_TEST;
  end else if (i_ce) begin
    intensity_digits_zero_one_q <= intensity_digits_zero_one_d;
    intensity_digits_two_three_q <= intensity_digits_two_three_d;
    test_q <= test_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Read back

// Stored values; upper bits of the test register read zero
always @* begin
  rdata_d = o_rdata;
  if (i_rd_addr_valid) begin
    case (i_addr)
      `ADDR_INTENSITY_01: begin
        rdata_d = intensity_digits_zero_one_q;
      end
      `ADDR_INTENSITY_23: begin
        rdata_d = intensity_digits_two_three_q;
      end
      `ADDR_LAMP_TEST: begin
        rdata_d = {7'h00, test_q}; // [R1]
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end
end

// Holds its value until the next read request
always @(posedge i_clk or negedge i_nrst) begin
  if (!i_nrst) begin
    o_rdata <= 8'h00;
  end else if (i_ce) begin
    o_rdata <= rdata_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Slot timing: 16 slots per digit period

assign slot_end = (slot_cnt_q == SLOT_CYCLES[7:0] - 8'h01);
assign period_end = slot_end && (slot_q == `SLOT_LAST);

// Slot index wraps from 15 to 0 on its own
always @* begin
  slot_cnt_d = slot_cnt_q + 8'h01;
  slot_d = slot_q;
  if (slot_end) begin
    slot_cnt_d = 8'h00;
    slot_d = slot_q + 4'h1; // [R7]
  end
end

always @(posedge i_clk or negedge i_nrst) begin
  if (!i_nrst) begin
    slot_cnt_q <= 8'h00;
    slot_q <= 4'h0;
  end else if (i_ce) begin
    slot_cnt_q <= slot_cnt_d;
    slot_q <= slot_d;
  end
end

// Settings sampled only at period boundary
always @(posedge i_clk or negedge i_nrst) begin
  if (!i_nrst) begin
    codes_q <= 16'h0000;
    test_live_q <= `RESET_TEST;
    o_period_start <= 1'b0;
  end else if (i_ce) begin
    o_period_start <= period_end;
    if (period_end) begin
      codes_q <= {intensity_digits_two_three_q,
                  intensity_digits_zero_one_q}; // [R8]
      test_live_q <= test_q; // [R8] [R6]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// One modulator per digit

genvar g;
generate
  for (g = 0; g < DIGITS; g = g + 1) begin : gen_pwm
    wire [3:0] code;
    wire [3:0] eff;
    wire on;
    assign code = codes_q[4*g+3:4*g];
    assign eff = (code == `SLOT_LAST) ? `MAX_CODE : code; // [R4]
    // Slot 15 always blank; slots 0..eff lit, or slots 0..6 in display test
    assign on = test_live_q ? (slot_q < `TEST_DUTY) // [R6]
                            : (slot_q <= eff); // [R4] [R7]
    always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        o_digit_on[g] <= 1'b0;
      end else if (i_ce) begin
        o_digit_on[g] <= on;
      end
    end
  end
endgenerate

always @(posedge i_clk or negedge i_nrst) begin
  if (!i_nrst) begin
    o_test_active <= 1'b0;
  end else if (i_ce) begin
    o_test_active <= test_live_q; // [R6]
  end
end

endmodule

// file: verif/bus_host.sv
// Purpose: Bus master model. Assumes: one request per call. Notes: none
`timescale 1ns/100ps
module bus_host(
  input wire i_clk,
  output reg o_wr,
  output reg o_rv,
  output reg [7:0] o_a,
  output reg [7:0] o_d);
  initial {o_wr,o_rv,o_a,o_d}=0;
  // Requests only after reset release
  task xfer(input w,input [7:0] ad,input [7:0] dd);
    begin
      @(negedge i_clk);
      {o_wr,o_rv,o_a,o_d}={w,!w,ad,dd};
      @(negedge i_clk);
      {o_wr,o_rv,o_a,o_d}={2'b00,~ad,~dd};
    end
  endtask
endmodule

// file: verif/digit_intensity_test_ctrl_props.sv
// Purpose: Checker. Assumes: ports only. Notes: none
`timescale 1ns/100ps
module dit_props #(parameter DIGITS=4,parameter SLOT_CYCLES=1)(
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_rd_addr_valid,
  input wire [7:0] o_rdata,
  input wire [DIGITS-1:0] o_digit_on,
  input wire o_test_active,
  input wire o_period_start);
  localparam int PER=16*SLOT_CYCLES;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_per; o_period_start |-> ##PER o_period_start; endproperty
  a_per: assert property (p_per) else $error("period");
  property p_dark; o_period_start |-> ##[0:PER] o_digit_on==0; endproperty
  a_dark: assert property (p_dark) else $error("no dark slot");
  property p_lit; o_period_start |-> ##[0:2] &o_digit_on; endproperty
  a_lit: assert property (p_lit) else $error("slot 0 dark");
  property p_tst; o_test_active |-> o_digit_on==0 || &o_digit_on;
  endproperty
  a_tst: assert property (p_tst) else $error("test mix");
  property p_rd7; i_rd_addr_valid && i_addr==8'h07 |=> o_rdata[7:1]==0;
  endproperty
  a_rd7: assert property (p_rd7) else $error("test bits");
  property p_wr; i_ce && i_wr && i_addr==8'h02 ##2 i_rd_addr_valid &&
    i_addr==8'h02 |=> o_rdata==$past(i_wdata,3); endproperty
  a_wr: assert property (p_wr) else $error("readback");
  property p_sync; $changed(o_test_active) |-> o_period_start ||
    $past(o_period_start) || $past(o_period_start,2); endproperty
  a_sync: assert property (p_sync) else $error("mid period");
endmodule
bind digit_intensity_test_ctrl dit_props #(.DIGITS(DIGITS),
  .SLOT_CYCLES(SLOT_CYCLES)) chk(.i_clk,.i_nrst,.i_ce,.i_wr,.i_addr,
  .i_wdata,.i_rd_addr_valid,.o_rdata,.o_digit_on,.o_test_active,
  .o_period_start);

// file: verif/testbench.sv
// Purpose: Bench. Assumes: SLOT_CYCLES 1. Notes: i_ce tied high
`timescale 1ns/100ps
module testbench;
  reg clk=0,nrst=0;
  wire wr,rv,tst,ps;
  wire [7:0] a,d,rd;
  wire [3:0] on;
  integer mismatches=0,checks_done=0,seed=55155,g,n;
  reg [7:0] r1,r2,cnt[0:3];
  initial forever #20 clk=~clk;
  bus_host host(.i_clk(clk),.o_wr(wr),.o_rv(rv),.o_a(a),.o_d(d));
  digit_intensity_test_ctrl #(.SLOT_CYCLES(1)) DUT(.i_clk(clk),
    .i_nrst(nrst),.i_ce(1'b1),.i_wr(wr),.i_addr(a),.i_wdata(d),
    .i_rd_addr_valid(rv),.o_rdata(rd),.o_digit_on(on),
    .o_test_active(tst),.o_period_start(ps));
  function [7:0] duty(input [3:0] c);
    duty=(c==4'hF)?8'h0F:c+1;
  endfunction
  task cmp(input [7:0] got,input [7:0] exp);
    begin
      checks_done=checks_done+1;
      if (got!==exp) begin
        mismatches=mismatches+1;
        $display("ERROR %0t got %h exp %h",$time,got,exp);
      end
    end
  endtask
  task chk(input [15:0] cd,input t);
    begin
      repeat (40) @(negedge clk);
      for (g=0;g<4;g=g+1) cnt[g]=0;
      repeat (16) begin
        @(negedge clk);
        for (g=0;g<4;g=g+1) cnt[g]=cnt[g]+on[g];
      end
      for (g=0;g<4;g=g+1) cmp(cnt[g],t?8'h07:duty(cd[4*g+:4]));
      cmp({7'h00,tst},{7'h00,t});
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d checks %0d",mismatches,checks_done);
      if (mismatches==0 && checks_done>0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst=1;
    for (n=0;n<6;n=n+1) begin
      r1=n?$random(seed):8'hF0;
      r2=n?$random(seed):8'hFE;
      host.xfer(1,8'h01,r1);
      host.xfer(1,8'h02,r2);
      host.xfer(0,8'h02,0);
      cmp(rd,r2);
      host.xfer(0,8'h01,0);
      cmp(rd,r1);
      chk({r2,r1},0);
    end
    host.xfer(1,8'h07,8'hFF);
    host.xfer(0,8'h07,0);
    cmp(rd,8'h01);
    chk(0,1);
    host.xfer(1,8'h07,8'hFE);
    host.xfer(1,8'h05,8'hFF);
    chk({r2,r1},0);
    host.xfer(0,8'h05,0);
    cmp(rd,8'h00);
    finish_test;
  end
endmodule
